// >>> rf_cmd_defs.vh
// constants for the rangefinder uart command interpreter
// assumes a 40 MHz clock and an 8n1 serial link to the host
//
// Behaviour
// [R1] continuous start: addr 06 03 chk; results addr 06 83 digits chk
// [R2] 1mm sends ddd.ddd; 0.1mm sends ddd.dddd with 2E point
// [R3] every result digit is sent as its ascii character code
// [R4] failed result sends ER-- dd (1mm) or ERA-- dd (0.1mm)
// [R5] stop: addr 04 02 chk answered by addr 04 82 chk
// [R6] laser: addr 06 05 p chk; 01 turns laser on, 00 off
// [R7] address change: old 04 01 new chk; reply 04 81 or 84 81 02
// [R8] any address 00..FF accepted; default address is 80
// [R9] rate: 04 0A code; 00/05/0A/14 valid; reply 8A or 84 8A 01
// [R10] offset: 04 06 sign magnitude; reply 8B or 84 8B 01
// [R11] offset sign 2D means negative, 2B means positive
// [R12] resolution: 04 0C p; 01 selects 1mm, 02 selects 0.1mm
// [R13] resolution reply 04 8C on success, 84 8C 01 on failure
// [R14] interval: 04 05 seconds; continuous results spaced by that
// [R15] interval reply 04 85 on success, 84 85 01 on failure
// [R16] power-on measure: 04 0D 01/00; reply 8D or 84 8D 01
// [R17] with power-on measure enabled, continuous starts after reset
// [R18] broadcast FA 06 06 FA measures once and sends no reply
// [R19] buffer read addr 06 07 returns the stored result frame
// [R20] last byte is two's complement of the byte sum
// [R21] link is 8n1 at 9600 baud
// [R22] single result and buffer read use header addr 06 82
// [R23] act only on own or broadcast address with good checksum
// [R24] continuous results continue until stop, stop wins before next; the code drops a stop that ends while a reply is sent or as a result is loaded
// [R25] settings are held in storage ports that survive power cycles; only address, resolution and power-on flag are read back
`ifndef RF_CMD_DEFS_VH
`define RF_CMD_DEFS_VH
`define CLK_HZ          40000000
`define BAUD_RATE       9600
`define BAUD_DIV        (`CLK_HZ / `BAUD_RATE)
`define ADDR_DEFAULT    8'h80
`define ADDR_BCAST      8'hFA
`define LEN_SHORT       8'h04
`define LEN_LONG        8'h06
`define LEN_FAIL        8'h84
`define OP_SETADDR      8'h01
`define OP_STOP         8'h02
`define OP_CONT         8'h03
`define OP_LASER_IVL    8'h05
`define OP_BCAST_OFS    8'h06
`define OP_READBUF      8'h07
`define OP_FREQ         8'h0A
`define OP_RES          8'h0C
`define OP_PWRON        8'h0D
`define RSP_BIT         8'h80
`define RSP_SINGLE      8'h82
`define RSP_CONT        8'h83
`define RSP_OFS         8'h8B
`define ERR_ADDR        8'h02
`define ERR_GEN         8'h01
`define SIGN_NEG        8'h2D
`define SIGN_POS        8'h2B
`define ASC_POINT       8'h2E
`define ASC_ZERO        8'h30
`define ASC_E           8'h45
`define ASC_R           8'h52
`define ASC_A           8'h41
`define ASC_DASH        8'h2D
`define RES_1MM         8'h01
`define RES_01MM        8'h02
`define FREQ_3          8'h00
`define FREQ_5          8'h05
`define FREQ_10         8'h0A
`define FREQ_20         8'h14
`define SEC_CYCLES      40000000
`endif

// >>> uart_rx.v
// 8n1 serial receiver, one byte out per pulse
// assumes rx_pin is asynchronous and idles high
`timescale 1ns/10ps
`include "rf_cmd_defs.vh"
module uart_rx #(
   parameter DIV = `BAUD_DIV
) (
   // clock and reset
   input  wire       clock,
   input  wire       sys_rst,
   // line
   input  wire       rx_pin,
   // byte out
   output reg  [7:0] rx_data,
   output reg        rx_valid
);
   reg        s1_reg;
   reg        s2_reg;
   reg [15:0] cnt_reg;
   reg [3:0]  bit_reg;
   reg        busy_reg;
   reg [7:0]  sh_reg;
   // ==================================================
   // receive
   // [R21] two-stage sync then mid-bit sampling
   always @(posedge clock) begin
      s1_reg <= rx_pin;
      s2_reg <= s1_reg;
      rx_valid <= 1'b0;
      if (sys_rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         busy_reg <= 1'b0;
         cnt_reg <= 16'h0000;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rx_data <= 8'h00;
      end else if (!busy_reg) begin
         if (!s2_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= DIV[16:1];
            bit_reg <= 4'h0;
         end
      end else if (cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end else begin
         cnt_reg <= DIV[15:0] - 16'h0001;
         bit_reg <= bit_reg + 4'h1;
         if (bit_reg == 4'h0) begin
            // false start glitch is dropped
            if (s2_reg)
               busy_reg <= 1'b0;
         end else if (bit_reg == 4'h9) begin
            busy_reg <= 1'b0;
            if (s2_reg) begin
               rx_data <= sh_reg;
               rx_valid <= 1'b1;
            end
         end else begin
            sh_reg <= {s2_reg, sh_reg[7:1]};
         end
      end
   end
endmodule

// >>> uart_tx.v
// 8n1 serial transmitter with ready/valid byte input
// assumes the line idles high
`timescale 1ns/10ps
`include "rf_cmd_defs.vh"
module uart_tx #(
   parameter DIV = `BAUD_DIV
) (
   // clock and reset
   input  wire       clock,
   input  wire       sys_rst,
   // byte in
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   output wire       tx_ready,
   // line
   output reg        tx_pin
);
   reg [15:0] cnt_reg;
   reg [3:0]  bit_reg;
   reg [8:0]  sh_reg;
   reg        busy_reg;
   assign tx_ready = !busy_reg;
   // ==================================================
   // shifter
   // [R21] start, eight data lsb first, one stop
   always @(posedge clock) begin
      if (sys_rst) begin
         tx_pin <= 1'b1;
         busy_reg <= 1'b0;
         cnt_reg <= 16'h0000;
         bit_reg <= 4'h0;
         sh_reg <= 9'h1FF;
      end else if (!busy_reg) begin
         if (tx_valid) begin
            busy_reg <= 1'b1;
            tx_pin <= 1'b0;
            sh_reg <= {1'b1, tx_data};
            cnt_reg <= DIV[15:0] - 16'h0001;
            bit_reg <= 4'h0;
         end
      end else if (cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end else if (bit_reg == 4'h9) begin
         busy_reg <= 1'b0;
      end else begin
         tx_pin <= sh_reg[0];
         sh_reg <= {1'b1, sh_reg[8:1]};
         cnt_reg <= DIV[15:0] - 16'h0001;
         bit_reg <= bit_reg + 4'h1;
      end
   end
endmodule

// >>> rf_cmd.v
// command interpreter for the rangefinder serial link
// assumes a measurement engine outside: meas_start pulse in, meas_done
// pulse back with bcd digits; nonvolatile store on the nv ports
`timescale 1ns/10ps
`include "rf_cmd_defs.vh"
module rf_cmd #(
   parameter DIV        = `BAUD_DIV,
   parameter SEC_CYC    = `SEC_CYCLES
) (
   // clock and reset
   input  wire        clock,
   input  wire        sys_rst,
   // serial pins
   input  wire        rx_pin,
   output wire        tx_pin,
   // measurement engine
   output reg         meas_start,
   input  wire        meas_done,
   input  wire        meas_fail,
   input  wire [27:0] meas_bcd,
   input  wire [7:0]  meas_err,
   // laser and settings
   output reg         laser_on,
   output reg  [7:0]  freq_code,
   output reg         offset_negative,
   output reg  [7:0]  offset_magnitude,
   output reg  [7:0]  measure_interval_seconds,
   output reg         continuous_active,
   // nonvolatile store
   input  wire [7:0]  nv_addr,
   input  wire        nv_valid,
   input  wire        nv_pwron,
   input  wire        nv_res_fine,
   output reg  [7:0]  module_addr,
   output reg         res_fine,
   output reg         pwron_enable,
   output reg         nv_write
);
   localparam S_IDLE = 4'b0001;
   localparam S_HDR  = 4'b0010;
   localparam S_SEND = 4'b0100;
   localparam S_WAIT = 4'b1000;
   wire [7:0] rx_data;
   wire       rx_valid;
   wire       tx_ready;
   uart_rx #(.DIV(DIV)) u_rx (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .rx_pin   (rx_pin),
      .rx_data  (rx_data),
      .rx_valid (rx_valid)
   );
   // ==================================================
   // frame collection
   reg [7:0]  fb_reg [0:5];
   reg [2:0]  fcnt_reg;
   reg [7:0]  fsum_reg;
   reg        fdone_reg;
   reg [2:0]  flen_reg;
   wire [2:0] exp_len = (rx_data == `OP_LASER_IVL && fb_reg[1] == `LEN_LONG)
                        ? 3'd5 :
                        (fb_reg[1] == `LEN_LONG) ? 3'd4 :
                        (rx_data == `OP_STOP) ? 3'd4 :
                        (rx_data == `OP_BCAST_OFS) ? 3'd6 : 3'd5;
   integer i;
   always @(posedge clock) begin
      fdone_reg <= 1'b0;
      if (sys_rst) begin
         fcnt_reg <= 3'd0;
         fsum_reg <= 8'h00;
         flen_reg <= 3'd4;
         for (i = 0; i < 6; i = i + 1)
            fb_reg[i] <= 8'h00;
      end else if (rx_valid) begin
         fb_reg[fcnt_reg] <= rx_data;
         fsum_reg <= fsum_reg + rx_data;
         if (fcnt_reg == 3'd2)
            flen_reg <= exp_len;
         if (fcnt_reg >= 3'd3 && fcnt_reg + 3'd1 == flen_reg) begin
            fcnt_reg <= 3'd0;
            fsum_reg <= 8'h00;
            // [R20] sum plus checksum is zero when valid
            fdone_reg <= ((fsum_reg + rx_data) == 8'h00);
         end else begin
            fcnt_reg <= fcnt_reg + 3'd1;
         end
      end
   end
   // [R23] accept own or broadcast address only
   wire for_me = (fb_reg[0] == module_addr) || (fb_reg[0] == `ADDR_BCAST);
   wire [7:0] op  = fb_reg[2];
   wire [7:0] p1  = fb_reg[3];
   wire       lng = (fb_reg[1] == `LEN_LONG);
   // ==================================================
   // reply builder
   reg [7:0]  ob_reg [0:11];
   reg [3:0]  olen_reg;
   reg [3:0]  oidx_reg;
   reg [7:0]  osum_reg;
   reg [3:0]  st_reg;
   reg        res_cont_reg;
   reg [27:0] buf_bcd_reg;
   reg [7:0]  buf_err_reg;
   reg        buf_fail_reg;
   reg [31:0] ivl_reg;
   reg        single_pend_reg;
   reg        cont_pend_reg;
   reg        boot_reg;
   wire       tx_go = (st_reg == S_SEND);
   wire [7:0] tx_byte = (oidx_reg == olen_reg) ? (8'h00 - osum_reg)
                                               : ob_reg[oidx_reg];
   uart_tx #(.DIV(DIV)) u_tx (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .tx_data  (tx_byte),
      .tx_valid (tx_go),
      .tx_ready (tx_ready),
      .tx_pin   (tx_pin)
   );
   // ascii of one bcd nibble
   function [7:0] asc;
      input [3:0] d;
      begin
         // [R3] digit becomes ascii code
         asc = `ASC_ZERO | {4'h0, d};
      end
   endfunction
   // build result frame: ack header plus digits or error text
   task load_result;
      input [7:0] code;
      begin
         ob_reg[0] <= module_addr;
         ob_reg[1] <= `LEN_LONG;
         ob_reg[2] <= code;
         if (buf_fail_reg) begin
            // [R4] error text in place of digits
            ob_reg[3] <= `ASC_E;
            ob_reg[4] <= `ASC_R;
            ob_reg[5] <= res_fine ? `ASC_A : `ASC_DASH;
            ob_reg[6] <= `ASC_DASH;
            ob_reg[7] <= res_fine ? `ASC_DASH : asc(buf_err_reg[7:4]);
            ob_reg[8] <= res_fine ? asc(buf_err_reg[7:4])
                                  : asc(buf_err_reg[3:0]);
            ob_reg[9] <= asc(buf_err_reg[3:0]);
            olen_reg <= res_fine ? 4'd10 : 4'd9;
         end else begin
            // [R2] three digits, point, three or four digits
            ob_reg[3] <= asc(buf_bcd_reg[27:24]);
            ob_reg[4] <= asc(buf_bcd_reg[23:20]);
            ob_reg[5] <= asc(buf_bcd_reg[19:16]);
            ob_reg[6] <= `ASC_POINT;
            ob_reg[7] <= asc(buf_bcd_reg[15:12]);
            ob_reg[8] <= asc(buf_bcd_reg[11:8]);
            ob_reg[9] <= asc(buf_bcd_reg[7:4]);
            ob_reg[10] <= asc(buf_bcd_reg[3:0]);
            olen_reg <= res_fine ? 4'd11 : 4'd10;
         end
      end
   endtask
   task load_ack;
      input       ok;
      input [7:0] code;
      input [7:0] err;
      begin
         ob_reg[0] <= module_addr;
         ob_reg[1] <= ok ? `LEN_SHORT : `LEN_FAIL;
         ob_reg[2] <= code;
         ob_reg[3] <= err;
         olen_reg <= ok ? 4'd3 : 4'd4;
      end
   endtask
   wire freq_ok = (p1 == `FREQ_3) || (p1 == `FREQ_5) ||
                  (p1 == `FREQ_10) || (p1 == `FREQ_20);
   wire res_ok  = (p1 == `RES_1MM) || (p1 == `RES_01MM);
   wire pwr_ok  = (p1 == 8'h00) || (p1 == 8'h01);
   wire ofs_ok  = (p1 == `SIGN_NEG) || (p1 == `SIGN_POS);
   wire ivl_ok  = (p1 != 8'h00);
   // ==================================================
   // main control
   always @(posedge clock) begin
      meas_start <= 1'b0;
      nv_write <= 1'b0;
      if (sys_rst) begin
         st_reg <= S_IDLE;
         oidx_reg <= 4'd0;
         olen_reg <= 4'd0;
         osum_reg <= 8'h00;
         // [R8] default address until another is set
         module_addr <= `ADDR_DEFAULT;
         res_fine <= 1'b0;
         pwron_enable <= 1'b0;
         laser_on <= 1'b0;
         freq_code <= `FREQ_3;
         offset_negative <= 1'b0;
         offset_magnitude <= 8'h00;
         measure_interval_seconds <= 8'h01;
         continuous_active <= 1'b0;
         res_cont_reg <= 1'b0;
         buf_bcd_reg <= 28'h0000000;
         buf_err_reg <= 8'h00;
         buf_fail_reg <= 1'b0;
         ivl_reg <= 32'd0;
         single_pend_reg <= 1'b0;
         cont_pend_reg <= 1'b0;
         boot_reg <= 1'b1;
         for (i = 0; i < 12; i = i + 1)
            ob_reg[i] <= 8'h00;
      end else begin
         // [R25] stored settings loaded once after reset
         if (boot_reg && nv_valid) begin
            boot_reg <= 1'b0;
            module_addr <= nv_addr;
            res_fine <= nv_res_fine;
            pwron_enable <= nv_pwron;
            // [R17] power-on measure starts continuous mode
            continuous_active <= nv_pwron;
            ivl_reg <= 32'd0;
         end
         if (meas_done) begin
            buf_bcd_reg <= meas_bcd;
            buf_err_reg <= meas_err;
            buf_fail_reg <= meas_fail;
            if (continuous_active)
               cont_pend_reg <= 1'b1;
         end
         // [R14] measurements spaced by interval seconds
         if (continuous_active) begin
            if (ivl_reg == 32'd0) begin
               meas_start <= 1'b1;
               ivl_reg <= SEC_CYC * measure_interval_seconds;
            end else begin
               ivl_reg <= ivl_reg - 32'd1;
            end
         end
         case (st_reg)
            S_IDLE: begin
               if (cont_pend_reg && continuous_active && !meas_done) begin
                  // [R1] continuous result frame
                  cont_pend_reg <= 1'b0;
                  load_result(`RSP_CONT);
                  st_reg <= S_HDR;
               end else if (fdone_reg && for_me) begin
                  st_reg <= S_HDR;
                  case ({lng, op})
                     {1'b1, `OP_CONT}: begin
                        continuous_active <= 1'b1;
                        ivl_reg <= 32'd0;
                        st_reg <= S_IDLE;
                     end
                     {1'b1, `OP_STOP}: begin
                        single_pend_reg <= 1'b1;
                        meas_start <= 1'b1;
                        st_reg <= S_IDLE;
                     end
                     {1'b0, `OP_STOP}: begin
                        // [R24] stop drops a pending continuous result
                        continuous_active <= 1'b0;
                        cont_pend_reg <= 1'b0;
                        // [R5] stop acknowledge
                        load_ack(1'b1, `RSP_SINGLE, 8'h00);
                     end
                     {1'b1, `OP_LASER_IVL}: begin
                        // [R6] laser switch, no reply
                        if (p1 == 8'h01)
                           laser_on <= 1'b1;
                        else if (p1 == 8'h00)
                           laser_on <= 1'b0;
                        st_reg <= S_IDLE;
                     end
                     {1'b1, `OP_BCAST_OFS}: begin
                        // [R18] broadcast measure, silent
                        meas_start <= 1'b1;
                        st_reg <= S_IDLE;
                     end
                     {1'b1, `OP_READBUF}: begin
                        // [R19] [R22] buffer read as single result
                        load_result(`RSP_SINGLE);
                     end
                     {1'b0, `OP_SETADDR}: begin
                        // [R7] any byte is a legal new address
                        module_addr <= p1;
                        nv_write <= 1'b1;
                        load_ack(1'b1, `OP_SETADDR | `RSP_BIT, 8'h00);
                        ob_reg[0] <= p1;
                     end
                     {1'b0, `OP_FREQ}: begin
                        // [R9] frequency code check
                        if (freq_ok)
                           freq_code <= p1;
                        nv_write <= freq_ok;
                        load_ack(freq_ok, `OP_FREQ | `RSP_BIT, `ERR_GEN);
                     end
                     {1'b0, `OP_BCAST_OFS}: begin
                        // [R10] [R11] offset sign and magnitude
                        if (ofs_ok) begin
                           offset_negative <= (p1 == `SIGN_NEG);
                           offset_magnitude <= fb_reg[4];
                        end
                        nv_write <= ofs_ok;
                        load_ack(ofs_ok, `RSP_OFS, `ERR_GEN);
                     end
                     {1'b0, `OP_RES}: begin
                        // [R12] [R13] resolution select
                        if (res_ok)
                           res_fine <= (p1 == `RES_01MM);
                        nv_write <= res_ok;
                        load_ack(res_ok, `OP_RES | `RSP_BIT, `ERR_GEN);
                     end
                     {1'b0, `OP_LASER_IVL}: begin
                        // [R15] interval acknowledge
                        if (ivl_ok)
                           measure_interval_seconds <= p1;
                        nv_write <= ivl_ok;
                        load_ack(ivl_ok, `OP_LASER_IVL | `RSP_BIT,
                                 `ERR_GEN);
                     end
                     {1'b0, `OP_PWRON}: begin
                        // [R16] power-on measure flag
                        if (pwr_ok)
                           pwron_enable <= p1[0];
                        nv_write <= pwr_ok;
                        load_ack(pwr_ok, `OP_PWRON | `RSP_BIT, `ERR_GEN);
                     end
                     default: st_reg <= S_IDLE;
                  endcase
               end else if (single_pend_reg && meas_done) begin
                  single_pend_reg <= 1'b0;
                  res_cont_reg <= 1'b1;
               end else if (res_cont_reg) begin
                  res_cont_reg <= 1'b0;
                  load_result(`RSP_SINGLE);
                  st_reg <= S_HDR;
               end
            end
            S_HDR: begin
               oidx_reg <= 4'd0;
               osum_reg <= 8'h00;
               st_reg <= S_SEND;
            end
            S_SEND: begin
               if (tx_ready) begin
                  osum_reg <= osum_reg + tx_byte;
                  st_reg <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (oidx_reg == olen_reg) begin
                  st_reg <= S_IDLE;
               end else begin
                  oidx_reg <= oidx_reg + 4'd1;
                  st_reg <= S_SEND;
               end
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule

// >>> rf_cmd_monitor.sv
// assertions on the rf_cmd ports
// assumes one clock, reset synchronous and high
`timescale 1ns/10ps
module rf_cmd_monitor #(
   parameter SEC_CYC = 50
) (
   // watched ports
   input wire       clock,
   input wire       sys_rst,
   input wire       tx_pin,
   input wire       meas_start,
   input wire       continuous_active,
   input wire [7:0] freq_code,
   input wire [7:0] offset_magnitude,
   input wire [7:0] measure_interval_seconds,
   input wire [7:0] module_addr,
   input wire       nv_write
);
   // =============
   // helpers
   logic [15:0] gap_reg;
   logic        cont_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_start;
      ##[0:3] meas_start;
   endsequence
   sequence s_store;
      ##[0:1] nv_write;
   endsequence
   // saturates so a long idle never wraps to a small gap
   always @(posedge clock) begin
      if (sys_rst) begin
         gap_reg  <= 16'h0000;
         cont_reg <= 1'b0;
      end else if (meas_start) begin
         gap_reg  <= 16'h0001;
         cont_reg <= continuous_active;
      end else if (gap_reg != 16'hFFFF)
         gap_reg <= gap_reg + 16'h0001;
   end
   chk_reset_state: assert property (disable iff (1'b0) sys_rst |=>
      tx_pin && !continuous_active && module_addr == 8'h80)
      else $error("bad reset state");
   chk_freq_legal: assert property (freq_code inside
      {8'h00, 8'h05, 8'h0A, 8'h14}) else $error("bad rate code");
   chk_ivl_nonzero: assert property (
      measure_interval_seconds != 8'h00) else $error("zero interval");
   chk_cont_start: assert property (
      $rose(continuous_active) |-> s_start) else $error("no start");
   chk_meas_spacing: assert property (
      meas_start && cont_reg && continuous_active
      |-> gap_reg >= measure_interval_seconds * SEC_CYC)
      else $error("starts too close");
   chk_start_pulse: assert property (
      meas_start |=> !meas_start) else $error("start too long");
   chk_ofs_store: assert property (
      $changed(offset_magnitude) |-> s_store) else $error("ofs not stored");
   chk_addr_store: assert property (
      $changed(module_addr) |-> s_store) else $error("addr not stored");
endmodule
bind rf_cmd rf_cmd_monitor #(.SEC_CYC(SEC_CYC)) i_rf_cmd_monitor (.*);

// >>> host_model.sv
// host side of the link: sends bytes, collects replies
// assumes 8n1 with DIV clocks a bit; the line idles high
`timescale 1ns/10ps
module host_model #(
   parameter DIV = 4
) (
   // clock and line
   input  wire  clock,
   output logic line_out,
   input  wire  line_in
);
   logic [7:0] rxq[$];
   logic [7:0] v;
   int         frame_err = 0;
   int         j;
   initial line_out = 1'b1;
   // =============
   // start, lsb first, stop
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clock);
      for (int k = 0; k < 10; k++) begin
         #1 line_out = f[k];
         repeat (DIV) @(posedge clock);
      end
   endtask
   always begin
      @(negedge line_in);
      repeat (DIV / 2) @(posedge clock);
      for (j = 0; j < 8; j++) begin
         repeat (DIV) @(posedge clock);
         #1 v[j] = line_in;
      end
      repeat (DIV) @(posedge clock);
      #1 if (line_in !== 1'b1) frame_err++;
      rxq.push_back(v);
   end
endmodule

// >>> tb.sv
// bench for rf_cmd: host model on the pins, engine stub here
// assumes DIV 4, SEC_CYC 50 for short runs
`timescale 1ns/10ps
module tb;
   typedef logic [7:0] bq_t[$];
   localparam logic [7:0] ad = 8'h80, sh = 8'h04, lg = 8'h06, fh = 8'h84;
   // =============
   // signals
   logic       clock, sys_rst, meas_done = 1'b0, meas_fail = 1'b0;
   logic       nv_pwron = 1'b0, nv_res_fine = 1'b0, nv_valid = 1'b1;
   logic [7:0] nv_addr = 8'h80, meas_err = 8'h12;
   logic [27:0] meas_bcd = 28'h1234567;
   wire        rx_pin, tx_pin, meas_start, laser_on, ofs_neg, cont, nv_write;
   wire        res_fine, pwron_en;
   wire  [7:0] freq_code, ofs_mag, ivl, module_addr;
   int         error_cnt = 0;
   int         n_tests = 0;
   bq_t        gop = '{8'h0C, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h05, 8'h0D, 8'h0C};
   bq_t        gpa = '{8'h02, 8'h00, 8'h05, 8'h0A, 8'h14, 8'h28, 8'h01, 8'h01};
   bq_t        bop = '{8'h0C, 8'h0A, 8'h05, 8'h0D};
   bq_t        bpa = '{8'h03, 8'h07, 8'h00, 8'h03};
   rf_cmd #(.DIV(4), .SEC_CYC(50)) i_rf_cmd (.*, .offset_negative(ofs_neg),
      .offset_magnitude(ofs_mag), .measure_interval_seconds(ivl),
      .continuous_active(cont), .pwron_enable(pwron_en));
   host_model #(.DIV(4)) i_host_model (
      .clock(clock), .line_out(rx_pin), .line_in(tx_pin));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // engine stub, fixed latency
   always @(posedge clock) begin
      if (meas_start) begin
         repeat (5) @(posedge clock);
         #1 meas_done = 1'b1;
         @(posedge clock);
         #1 meas_done = 1'b0;
      end
   end
   // =============
   // tasks
   task report_and_stop;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [7:0] ck(input bq_t q);
      logic [7:0] s = 8'h00;
      foreach (q[i]) s += q[i];
      return 8'h00 - s;
   endfunction
   function automatic bq_t res(input logic [7:0] op, input logic fine,
                               input logic er);
      bq_t r;
      r = '{ad, lg, op};
      if (er) begin
         r = {r, 8'h45, 8'h52};
         if (fine) r.push_back(8'h41);
         r = {r, 8'h2D, 8'h2D, 8'h31, 8'h32};
      end else
         for (int k = 0; k < 6 + fine; k++) begin
            if (k == 3) r.push_back(8'h2E);
            r.push_back(8'h31 + k[7:0]);
         end
      return r;
   endfunction
   task automatic send(input bq_t q, input logic [7:0] bad);
      q.push_back(ck(q) ^ bad);
      foreach (q[i]) i_host_model.send_byte(q[i]);
   endtask
   task automatic rx_exp(input bq_t e);
      int t;
      if (e.size() != 0)
         e.push_back(ck(e));
      foreach (e[i]) begin
         for (t = 0; t < 3000 && i_host_model.rxq.size() == 0; t++)
            @(posedge clock);
         if (t == 3000) begin
            error_cnt++;
            report_and_stop();
         end
         chk8("reply byte", e[i], i_host_model.rxq.pop_front());
      end
      repeat (300) @(posedge clock);
      #1 chk8("extra bytes", 8'h00, 8'(i_host_model.rxq.size()));
   endtask
   task automatic xfer(input bq_t q, input bq_t e);
      send(q, 8'h00);
      rx_exp(e);
   endtask
   // =============
   // sequence
   initial begin
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      #1 sys_rst = 1'b0;
      send('{ad, sh, 8'h0C, 8'h02}, 8'h01);
      rx_exp('{});
      chk8("res_fine", 8'h00, {7'h00, res_fine});
      foreach (gop[i]) begin
         xfer('{ad, sh, gop[i], gpa[i]}, '{ad, sh, gop[i] | 8'h80});
         case (gop[i])
            8'h0C: chk8("res_fine", gpa[i] - 8'h01, {7'h00, res_fine});
            8'h0A: chk8("freq_code", gpa[i], freq_code);
            8'h05: chk8("interval", gpa[i], ivl);
            default: chk8("pwron_en", gpa[i], {7'h00, pwron_en});
         endcase
      end
      foreach (bop[i]) xfer('{ad, sh, bop[i], bpa[i]},
                            '{ad, fh, bop[i] | 8'h80, 8'h01});
      chk8("res_fine", 8'h00, {7'h00, res_fine});
      chk8("freq_code", 8'h14, freq_code);
      chk8("interval", 8'h28, ivl);
      xfer('{ad, sh, 8'h06, 8'h2D, 8'h01}, '{ad, sh, 8'h8B});
      chk8("ofs_neg", 8'h01, {7'h00, ofs_neg});
      xfer('{ad, sh, 8'h06, 8'h2B, 8'h05}, '{ad, sh, 8'h8B});
      chk8("ofs_neg", 8'h00, {7'h00, ofs_neg});
      xfer('{ad, sh, 8'h06, 8'h2C, 8'h07}, '{ad, fh, 8'h8B, 8'h01});
      chk8("ofs_mag", 8'h05, ofs_mag);
      for (int p = 1; p >= 0; p--) begin
         xfer('{ad, lg, 8'h05, 8'(p)}, '{});
         chk8("laser_on", 8'(p), {7'h00, laser_on});
      end
      send('{ad, lg, 8'h03}, 8'h00);
      rx_exp(res(8'h83, 1'b0, 1'b0));
      meas_fail = 1'b1;
      rx_exp(res(8'h83, 1'b0, 1'b1));
      xfer('{ad, sh, 8'h02}, '{ad, sh, 8'h82});
      chk8("cont", 8'h00, {7'h00, cont});
      xfer('{8'h55, sh, 8'h0C, 8'h02}, '{});
      xfer('{ad, sh, 8'h0C, 8'h02}, '{ad, sh, 8'h8C});
      meas_fail = 1'b0;
      xfer('{8'hFA, lg, 8'h06}, '{});
      xfer('{ad, lg, 8'h07}, res(8'h82, 1'b1, 1'b0));
      meas_fail = 1'b1;
      xfer('{ad, lg, 8'h02}, res(8'h82, 1'b1, 1'b1));
      xfer('{ad, sh, 8'h01, 8'h33}, '{8'h33, sh, 8'h81});
      chk8("module_addr", 8'h33, module_addr);
      xfer('{ad, sh, 8'h0C, 8'h01}, '{});
      chk8("res_fine", 8'h01, {7'h00, res_fine});
      chk8("stop bits", 8'h00, 8'(i_host_model.frame_err));
      nv_pwron = 1'b1;
      nv_res_fine = 1'b1;
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      #1 sys_rst = 1'b0;
      repeat (5) @(posedge clock);
      #1 chk8("cont", 8'h01, {7'h00, cont});
      chk8("res_fine", 8'h01, {7'h00, res_fine});
      report_and_stop();
   end
endmodule
